// ### inc/thm_pkg.sv
// Constants, types and register map for the two compare timer units.
// Assumes a Wishbone slave that decodes word indexes; data is one byte.
// What this block does
// - Run bit low stops and clears counter
// - Run bit high counts on next tick
// - Unit 0 clock select decodes six sources
// - Unit 1 clock select decodes eight sources
// - Unit 0 modes: interval or PWM
// - Unit 1 modes: interval, carrier, PWM
// - Bit 1 default level, bit 0 enable
// - Identical rewrite while running disturbs nothing
// - Pin level uses latch too; direction sets only the enable
// - Reset loads mode registers with zero
// - Mode registers take bit and byte writes
// - Interval match raises request, clears counter
package thm_pkg;
   localparam int THM_DW = 8;
   localparam int THM_IDX_W = 18;
   localparam logic [17:0] THM_IDX_MODE0 = 18'h0FF69;
   localparam logic [17:0] THM_IDX_MODE1 = 18'h0FF6C;
   localparam logic [17:0] THM_IDX_CMP00 = 18'h0FF18;
   localparam logic [17:0] THM_IDX_UNIT0_COMPARE1 = 18'h0FF19;
   localparam logic [17:0] THM_IDX_CMP01 = 18'h0FF1A;
   localparam logic [17:0] THM_IDX_UNIT1_COMPARE1 = 18'h0FF1B;
   localparam logic [17:0] THM_IDX_PORT = 18'h0FF80;
   localparam logic [17:0] THM_IDX_BITOP = 18'h0FF81;
   localparam logic [17:0] THM_IDX_CNT0 = 18'h0FF82;
   localparam logic [17:0] THM_IDX_CNT1 = 18'h0FF83;
   localparam logic [7:0] THM_MODE_RST = 8'h00;
   localparam logic [7:0] THM_CMP_RST = 8'h00;
   localparam logic [3:0] THM_PORT_RST = 4'h5;
   localparam int THM_PA_DIR = 0;
   localparam int THM_PA_LAT = 1;
   localparam int THM_PB_DIR = 2;
   localparam int THM_PB_LAT = 3;
   localparam int THM_BOP_IDX = 0;
   localparam int THM_BOP_VAL = 3;
   localparam int THM_BOP_UNIT = 4;
   localparam int THM_RUN_BIT = 7;
   localparam int THM_PRE_W = 12;
   localparam int THM_E_DIV2 = 1;
   localparam int THM_E_DIV4 = 2;
   localparam int THM_E_DIV16 = 4;
   localparam int THM_E_DIV64 = 6;
   localparam int THM_E_DIV1024 = 10;
   localparam int THM_E_DIV4096 = 12;
   localparam int THM_RL_W = 9;
   localparam int THM_RL_E128 = 7;
   localparam int THM_RL_E512 = 9;
   localparam logic [2:0] THM_CK_FPRS = 3'h0;
   localparam logic [2:0] THM_U0_DIV2 = 3'h1;
   localparam logic [2:0] THM_U0_DIV4 = 3'h2;
   localparam logic [2:0] THM_U0_DIV64 = 3'h3;
   localparam logic [2:0] THM_U0_DIV1024 = 3'h4;
   localparam logic [2:0] THM_U0_EVENT = 3'h5;
   localparam logic [2:0] THM_U1_DIV4 = 3'h1;
   localparam logic [2:0] THM_U1_DIV16 = 3'h2;
   localparam logic [2:0] THM_U1_DIV64 = 3'h3;
   localparam logic [2:0] THM_U1_DIV4096 = 3'h4;
   localparam logic [2:0] THM_U1_RL128 = 3'h5;
   localparam logic [2:0] THM_U1_RL512 = 3'h6;
   localparam logic [2:0] THM_U1_RL = 3'h7;

   typedef enum logic [1:0] {
      THM_INTERVAL = 2'b00,
      THM_CARRIER = 2'b01,
      THM_PWM = 2'b10,
      THM_BADMODE = 2'b11
   } thm_mode_e;

   typedef struct packed {
      logic run;
      logic [2:0] cks;
      thm_mode_e mode;
      logic lev;
      logic oen;
   } thm_ctl_s;
endpackage

// ### src/thm_top.sv
// Mode control, clock selection and Wishbone registers for two timers.
// Assumes rl_tick_i pulses once per low-speed oscillator period and
// ev0_out_i is the first event counter's output level, both synchronous.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/100ps
module thm_top #(
   parameter int ADR_W = 20,
   parameter int PRE_W = thm_pkg::THM_PRE_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Count clock sources
   input wire logic rl_tick_i,
   input wire logic ev0_out_i,
   // Interrupt requests
   output logic irq0_o,
   output logic irq1_o,
   // Timer output pins
   output logic pin_a_o,
   output logic pin_a_oe_o,
   output logic pin_b_o,
   output logic pin_b_oe_o
);
   import thm_pkg::*;

   if (ADR_W < THM_IDX_W + 2) begin : g_chk_adr
      $error("Address too narrow for the register indexes.");
   end
   if (PRE_W < THM_E_DIV4096) begin : g_chk_pre
      $error("Prescaler too narrow for the slowest divider.");
   end

   thm_ctl_s md0;
   thm_ctl_s md1;
   thm_ctl_s next_md0;
   thm_ctl_s next_md1;
   logic [7:0] c00;
   logic [7:0] c10;
   logic [7:0] c01;
   logic [7:0] c11;
   logic [7:0] next_c00;
   logic [7:0] next_c10;
   logic [7:0] next_c01;
   logic [7:0] next_c11;
   logic [7:0] pend10;
   logic [7:0] pend11;
   logic [7:0] next_pend10;
   logic [7:0] next_pend11;
   logic pv10;
   logic pv11;
   logic next_pv10;
   logic next_pv11;
   logic [3:0] port;
   logic [3:0] next_port;
   logic [31:0] next_dat;
   logic next_ack;
   logic [PRE_W-1:0] pre;
   logic [THM_RL_W-1:0] rl_cnt;
   logic ev_q;
   logic [PRE_W:0] dtk;
   logic rl128;
   logic rl512;
   logic ev_rise;
   logic tick0;
   logic tick1;
   logic ok0;
   logic ok1;
   logic [7:0] cnt0;
   logic [7:0] cnt1;
   logic m10;
   logic m11;
   logic tout0;
   logic tout1;
   logic req;
   logic wr;
   logic [THM_IDX_W-1:0] idx;
   logic [7:0] d;
   logic [7:0] bop;

   // A write while running may only move the run bit, so a refresh with
   // the same value is harmless and a stray change cannot corrupt a count.
   function automatic thm_ctl_s wr_mode(thm_ctl_s old, logic [7:0] v);
      thm_ctl_s r;
      r = thm_ctl_s'(v);
      if (old.run) begin
         r = old;
         r.run = v[THM_RUN_BIT];
      end
      return r;
   endfunction

   // Main-clock divided rates are strobes from one free-running prescaler; the low-speed ones come from rl_cnt.
   assign dtk[0] = 1'b1;
   for (genvar k = 1; k <= PRE_W; k++) begin : g_div
      assign dtk[k] = &pre[k-1:0];
   end
   assign rl128 = rl_tick_i & (&rl_cnt[THM_RL_E128-1:0]);
   assign rl512 = rl_tick_i & (&rl_cnt[THM_RL_E512-1:0]);
   assign ev_rise = ev0_out_i & ~ev_q;

   always_comb begin
      unique case (md0.cks)
         THM_CK_FPRS: tick0 = dtk[0];
         THM_U0_DIV2: tick0 = dtk[THM_E_DIV2];
         THM_U0_DIV4: tick0 = dtk[THM_E_DIV4];
         THM_U0_DIV64: tick0 = dtk[THM_E_DIV64];
         THM_U0_DIV1024: tick0 = dtk[THM_E_DIV1024];
         THM_U0_EVENT: tick0 = ev_rise;
         default: tick0 = 1'b0;
      endcase
      unique case (md1.cks)
         THM_CK_FPRS: tick1 = dtk[0];
         THM_U1_DIV4: tick1 = dtk[THM_E_DIV4];
         THM_U1_DIV16: tick1 = dtk[THM_E_DIV16];
         THM_U1_DIV64: tick1 = dtk[THM_E_DIV64];
         THM_U1_DIV4096: tick1 = dtk[THM_E_DIV4096];
         THM_U1_RL128: tick1 = rl128;
         THM_U1_RL512: tick1 = rl512;
         THM_U1_RL: tick1 = rl_tick_i;
      endcase
      ok0 = md0.mode == THM_INTERVAL || md0.mode == THM_PWM;
      ok1 = md1.mode != THM_BADMODE;
   end

   thm_unit #(.W(THM_DW)) u_unit0 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick0 & ok0),
      .ctl_i(md0),
      .cmp0_i(c00),
      .cmp1_i(c10),
      .cnt_o(cnt0),
      .irq_o(irq0_o),
      .match1_o(m10),
      .tout_o(tout0)
   );

   thm_unit #(.W(THM_DW)) u_unit1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick1 & ok1),
      .ctl_i(md1),
      .cmp0_i(c01),
      .cmp1_i(c11),
      .cnt_o(cnt1),
      .irq_o(irq1_o),
      .match1_o(m11),
      .tout_o(tout1)
   );

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign idx = wb_adr_i[THM_IDX_W+1:2];
   assign d = wb_dat_i[7:0];

   always_comb begin
      next_md0 = md0;
      next_md1 = md1;
      next_c00 = c00;
      next_c01 = c01;
      next_c10 = c10;
      next_c11 = c11;
      next_pend10 = pend10;
      next_pend11 = pend11;
      next_pv10 = pv10 & md0.run;
      next_pv11 = pv11 & md1.run;
      next_port = port;
      bop = '0;
      // A pending compare-1 value moves in at its match.
      if (m10 && pv10) begin
         next_c10 = pend10;
         next_pv10 = 1'b0;
      end
      if (m11 && pv11) begin
         next_c11 = pend11;
         next_pv11 = 1'b0;
      end
      if (wr) begin
         unique case (idx)
            THM_IDX_MODE0: next_md0 = wr_mode(md0, d);
            THM_IDX_MODE1: next_md1 = wr_mode(md1, d);
            THM_IDX_BITOP: begin
               bop = d[THM_BOP_UNIT] ? md1 : md0;
               bop[d[THM_BOP_IDX+:3]] = d[THM_BOP_VAL];
               if (d[THM_BOP_UNIT]) begin
                  next_md1 = wr_mode(md1, bop);
               end else begin
                  next_md0 = wr_mode(md0, bop);
               end
            end
            THM_IDX_CMP00: if (!md0.run) next_c00 = d;
            THM_IDX_CMP01: if (!md1.run) next_c01 = d;
            THM_IDX_UNIT0_COMPARE1: begin
               if (!md0.run) begin
                  next_c10 = d;
               end else begin
                  next_pend10 = d;
                  next_pv10 = 1'b1;
               end
            end
            THM_IDX_UNIT1_COMPARE1: begin
               if (!md1.run) begin
                  next_c11 = d;
               end else begin
                  next_pend11 = d;
                  next_pv11 = 1'b1;
               end
            end
            THM_IDX_PORT: next_port = d[3:0];
            default: next_port = port;
         endcase
      end
   end

   always_comb begin
      next_ack = req;
      next_dat = '0;
      if (req && !wb_we_i) begin
         unique case (idx)
            THM_IDX_MODE0: next_dat[7:0] = md0;
            THM_IDX_MODE1: next_dat[7:0] = md1;
            THM_IDX_CMP00: next_dat[7:0] = c00;
            THM_IDX_UNIT0_COMPARE1: next_dat[7:0] = c10;
            THM_IDX_CMP01: next_dat[7:0] = c01;
            THM_IDX_UNIT1_COMPARE1: next_dat[7:0] = c11;
            THM_IDX_PORT: next_dat[3:0] = port;
            THM_IDX_CNT0: next_dat[7:0] = cnt0;
            THM_IDX_CNT1: next_dat[7:0] = cnt1;
            default: next_dat = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         md0 <= thm_ctl_s'(THM_MODE_RST);
         md1 <= thm_ctl_s'(THM_MODE_RST);
         c00 <= THM_CMP_RST;
         c10 <= THM_CMP_RST;
         c01 <= THM_CMP_RST;
         c11 <= THM_CMP_RST;
         pend10 <= THM_CMP_RST;
         pend11 <= THM_CMP_RST;
         pv10 <= 1'b0;
         pv11 <= 1'b0;
         port <= THM_PORT_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         pre <= '0;
         rl_cnt <= '0;
         ev_q <= 1'b0;
         pin_a_o <= 1'b0;
         pin_a_oe_o <= 1'b0;
         pin_b_o <= 1'b0;
         pin_b_oe_o <= 1'b0;
      end else begin
         md0 <= next_md0;
         md1 <= next_md1;
         c00 <= next_c00;
         c10 <= next_c10;
         c01 <= next_c01;
         c11 <= next_c11;
         pend10 <= next_pend10;
         pend11 <= next_pend11;
         pv10 <= next_pv10;
         pv11 <= next_pv11;
         port <= next_port;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
         pre <= pre + 1'b1;
         if (rl_tick_i) begin
            rl_cnt <= rl_cnt + 1'b1;
         end
         ev_q <= ev0_out_i;
         // Latch high forces the pin high; timer output needs it low.
         pin_a_o <= port[THM_PA_LAT] | tout0;
         pin_a_oe_o <= ~port[THM_PA_DIR];
         pin_b_o <= port[THM_PB_LAT] | tout1;
         pin_b_oe_o <= ~port[THM_PB_DIR];
      end
   end
endmodule

// ### src/thm_unit.sv
// One 8-bit compare counter with its timer output flip-flop.
// Assumes tick_i is a one-cycle enable already gated by code legality.
`timescale 1ns/100ps
module thm_unit #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic tick_i,
   input wire thm_pkg::thm_ctl_s ctl_i,
   input wire logic [W-1:0] cmp0_i,
   input wire logic [W-1:0] cmp1_i,
   // Results
   output logic [W-1:0] cnt_o,
   output logic irq_o,
   output logic match1_o,
   output logic tout_o
);
   import thm_pkg::*;

   logic [W-1:0] next_cnt;
   logic next_irq;
   logic next_match1;
   logic out;
   logic next_out;

   if (W < 1) begin : g_chk
      $error("Counter width must be positive.");
   end

   always_comb begin
      next_cnt = cnt_o;
      next_out = out;
      next_irq = 1'b0;
      next_match1 = 1'b0;
      if (!ctl_i.run) begin
         next_cnt = '0;
         next_out = ctl_i.lev;
      end else if (tick_i) begin
         next_cnt = cnt_o + 1'b1;
         unique case (ctl_i.mode)
            THM_INTERVAL: begin
               if (cnt_o == cmp0_i) begin
                  next_cnt = '0;
                  next_irq = 1'b1;
                  next_out = ~out;
               end
            end
            THM_PWM: begin
               if (cnt_o == cmp0_i) begin
                  next_cnt = '0;
                  next_irq = 1'b1;
                  next_out = ~ctl_i.lev;
               end else if (cnt_o == cmp1_i) begin
                  next_out = ctl_i.lev;
                  next_match1 = 1'b1;
               end
            end
            THM_CARRIER: begin
               if (cnt_o == cmp1_i) begin
                  next_cnt = '0;
                  next_irq = 1'b1;
                  next_out = ~out;
                  next_match1 = 1'b1;
               end else if (cnt_o == cmp0_i) begin
                  next_out = ~out;
               end
            end
            default: begin
               next_cnt = cnt_o;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_o <= '0;
         out <= 1'b0;
         irq_o <= 1'b0;
         match1_o <= 1'b0;
         tout_o <= 1'b0;
      end else begin
         cnt_o <= next_cnt;
         out <= next_out;
         irq_o <= next_irq;
         match1_o <= next_match1;
         tout_o <= ctl_i.oen & next_out;
      end
   end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the two-unit timer mode block.
// Drives the register bus, the low-speed tick and the event source.
`timescale 1ns/100ps
module tb_top;
   import thm_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [19:0] wb_adr_i = 20'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, irq0_o, irq1_o;
   logic rl_tick_i = 1'b0;
   logic ev0_out_i = 1'b0;
   logic pin_a_o, pin_a_oe_o, pin_b_o, pin_b_oe_o;
   logic [7:0] rd;
   logic [8:0] bad [5] = '{9'h0E0, 9'h0F0, 9'h084, 9'h08C, 9'h18C};
   int errors = 0;
   int samples_checked = 0;
   int ph = 0;
   int n;
   always #20 clk_i = ~clk_i;
   thm_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rl_tick_i(rl_tick_i), .ev0_out_i(ev0_out_i),
      .irq0_o(irq0_o), .irq1_o(irq1_o), .pin_a_o(pin_a_o),
      .pin_a_oe_o(pin_a_oe_o), .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o));
   // Low-speed tick every third cycle, event rising edge every sixth.
   always @(posedge clk_i) begin
      ph <= (ph + 1) % 6;
      rl_tick_i <= (ph % 3) == 0;
      ev0_out_i <= ph < 3;
   end
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [17:0] idx,
         input logic [7:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // The bound covers the slowest source with margin to spare.
   task automatic wait_irq(input logic u, output int k);
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while ((u ? irq1_o : irq0_o) !== 1'b1 && k < 14000);
   endtask
   function automatic int divisor(input logic u, input logic [2:0] c);
      int t0 [6] = '{1, 2, 4, 64, 1024, 6};
      int t1 [8] = '{1, 4, 16, 64, 4096, 384, 1536, 3};
      return u ? t1[c] : t0[c];
   endfunction
   task automatic run_case(input logic u, input logic [2:0] c,
         input thm_mode_e m);
      logic [7:0] n0;
      logic [17:0] mi;
      int p;
      int e;
      n0 = 8'(1 + $urandom % 2);
      mi = u ? THM_IDX_MODE1 : THM_IDX_MODE0;
      wb(1'b1, mi, 8'h00);
      wb(1'b1, u ? THM_IDX_CMP01 : THM_IDX_CMP00, n0);
      wb(1'b1, u ? THM_IDX_UNIT1_COMPARE1 : THM_IDX_UNIT0_COMPARE1, n0 + 8'h01);
      wb(1'b1, mi, {1'b1, c, m, 2'b01});
      wait_irq(u, p);
      wait_irq(u, p);
      e = (n0 + 1 + (m == THM_CARRIER)) * divisor(u, c);
      check(p, e);
      wb(1'b1, mi, 8'h00);
      wb(1'b0, u ? THM_IDX_CNT1 : THM_IDX_CNT0, 8'h00);
      check(rd, 8'h00);
   endtask
   initial begin
      #(40 * 90000);
      errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hdeda0b28));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, THM_IDX_MODE0, 8'h00);
      check(rd, 8'h00);
      wb(1'b0, THM_IDX_MODE1, 8'h00);
      check(rd, 8'h00);
      wb(1'b1, 18'h00010, 8'hFF);
      wb(1'b0, 18'h00010, 8'h00);
      check(rd, 8'h00);
      wb(1'b1, THM_IDX_BITOP, 8'h0B);
      wb(1'b0, THM_IDX_MODE0, 8'h00);
      check(rd, 8'h08);
      wb(1'b1, THM_IDX_BITOP, 8'h19);
      wb(1'b0, THM_IDX_MODE1, 8'h00);
      check(rd, 8'h02);
      wb(1'b1, THM_IDX_PORT, 8'h00);
      for (int k = 3; k >= 0; k--) begin
         wb(1'b1, THM_IDX_MODE0, 8'(k));
         wb(1'b1, THM_IDX_MODE1, 8'(k));
         repeat (8) @(posedge clk_i);
         check(pin_a_o, k == 3);
         check(pin_b_o, k == 3);
         check(pin_a_oe_o & pin_b_oe_o, 1'b1);
      end
      wb(1'b1, THM_IDX_PORT, 8'h0A);
      repeat (8) @(posedge clk_i);
      check({pin_a_o, pin_b_o}, 2'b11);
      for (int c = 0; c < 6; c++) run_case(1'b0, 3'(c), THM_INTERVAL);
      for (int c = 0; c < 8; c++) run_case(1'b1, 3'(c), THM_INTERVAL);
      run_case(1'b0, 3'($urandom % 3), THM_PWM);
      run_case(1'b1, 3'($urandom % 3), THM_CARRIER);
      run_case(1'b1, 3'($urandom % 3), THM_PWM);
      wb(1'b1, THM_IDX_CMP00, 8'h03);
      wb(1'b1, THM_IDX_MODE0, 8'h81);
      wb(1'b1, THM_IDX_MODE0, 8'h81);
      wb(1'b1, THM_IDX_MODE0, 8'hBD);
      wb(1'b0, THM_IDX_MODE0, 8'h00);
      check(rd, 8'h81);
      wait_irq(1'b0, n);
      wait_irq(1'b0, n);
      check(n, 4);
      foreach (bad[i]) begin
         wb(1'b1, bad[i][8] ? THM_IDX_MODE1 : THM_IDX_MODE0, 8'h00);
         wb(1'b1, bad[i][8] ? THM_IDX_MODE1 : THM_IDX_MODE0, bad[i][7:0]);
         repeat (20) @(posedge clk_i);
         wb(1'b0, bad[i][8] ? THM_IDX_CNT1 : THM_IDX_CNT0, 8'h00);
         check(rd, 8'h00);
      end
      // A compare-1 write while running waits for the old match.
      wb(1'b1, THM_IDX_MODE1, 8'h00);
      wb(1'b1, THM_IDX_CMP01, 8'h01);
      wb(1'b1, THM_IDX_UNIT1_COMPARE1, 8'h03);
      wb(1'b1, THM_IDX_MODE1, 8'h85);
      wb(1'b1, THM_IDX_UNIT1_COMPARE1, 8'h05);
      wait_irq(1'b1, n);
      wait_irq(1'b1, n);
      check(n, 6);
      // Reset again while unit 1 runs and unit 0 holds a bad code.
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, THM_IDX_MODE0, 8'h00);
      check(rd, 8'h00);
      wb(1'b0, THM_IDX_MODE1, 8'h00);
      check(rd, 8'h00);
      wb(1'b0, THM_IDX_CNT1, 8'h00);
      check(rd, 8'h00);
      give_verdict();
   end
endmodule
bind thm_top thm_top_assertions #(.ADR_W(ADR_W), .PRE_W(PRE_W)) chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .rl_tick_i(rl_tick_i), .ev0_out_i(ev0_out_i),
   .irq0_o(irq0_o), .irq1_o(irq1_o), .pin_a_o(pin_a_o),
   .pin_a_oe_o(pin_a_oe_o), .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o));

// ### tb/thm_top_assertions.sv
// Port-level checker for the two-unit timer mode block.
// Assumes byte writes on sel[0] and the bit-access register.
`timescale 1ns/100ps
module thm_top_assertions #(
   parameter int ADR_W = 20,
   parameter int PRE_W = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Sources and results
   input wire logic rl_tick_i,
   input wire logic ev0_out_i,
   input wire logic irq0_o,
   input wire logic irq1_o,
   input wire logic pin_a_o,
   input wire logic pin_a_oe_o,
   input wire logic pin_b_o,
   input wire logic pin_b_oe_o
);
   import thm_pkg::*;
   logic [7:0] m0, m1, next_m0, next_m1;
   logic [3:0] prt, next_prt;
   logic [2:0] quiet, next_quiet;
   logic [17:0] idx;
   logic wr;
   assign idx = 18'(wb_adr_i[ADR_W-1:2]);
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   // A running unit keeps all but its run bit, so the shadow does too.
   function automatic logic [7:0] upd(input logic [7:0] o,
         input logic [7:0] n);
      return o[7] ? {n[7], o[6:0]} : n;
   endfunction
   function automatic logic [7:0] bop(input logic [7:0] o,
         input logic [7:0] d);
      logic [7:0] r;
      r = o;
      r[d[2:0]] = d[3];
      return upd(o, r);
   endfunction
   always_comb begin
      next_m0 = m0;
      next_m1 = m1;
      next_prt = prt;
      next_quiet = (quiet == 3'h7) ? quiet : quiet + 3'h1;
      if (wr) begin
         next_quiet = 3'h0;
         if (idx == THM_IDX_MODE0) next_m0 = upd(m0, wb_dat_i[7:0]);
         if (idx == THM_IDX_MODE1) next_m1 = upd(m1, wb_dat_i[7:0]);
         if (idx == THM_IDX_PORT) next_prt = wb_dat_i[3:0];
         if (idx == THM_IDX_BITOP && !wb_dat_i[4]) begin
            next_m0 = bop(m0, wb_dat_i[7:0]);
         end
         if (idx == THM_IDX_BITOP && wb_dat_i[4]) begin
            next_m1 = bop(m1, wb_dat_i[7:0]);
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         m0 <= THM_MODE_RST;
         m1 <= THM_MODE_RST;
         prt <= THM_PORT_RST;
         quiet <= 3'h0;
      end else begin
         m0 <= next_m0;
         m1 <= next_m1;
         prt <= next_prt;
         quiet <= next_quiet;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_read_high_zero: assert property (
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_reset_quiet: assert property (disable iff (1'b0)
      rst_i |=> !(wb_ack_o | irq0_o | irq1_o | pin_a_o | pin_b_o
      | pin_a_oe_o | pin_b_oe_o)) else $error("output high after reset");
   a_stop_no_irq: assert property (quiet == 3'h7 |->
      (m0[7] || !irq0_o) && (m1[7] || !irq1_o))
      else $error("stopped unit raised a request");
   a_bad_code_hold: assert property (quiet == 3'h7 |->
      !(irq0_o && (m0[6:5] == 2'b11 || m0[2]))
      && !(irq1_o && m1[3:2] == 2'b11))
      else $error("prohibited code still counted");
   a_oe_direction: assert property (1'b1 |->
      pin_a_oe_o == !$past(prt[0]) && pin_b_oe_o == !$past(prt[2]))
      else $error("pin enable does not follow direction");
   a_pin_a_level: assert property (
      quiet == 3'h7 && !m0[7] && !prt[0] |->
      pin_a_o == (prt[1] | (m0[1] & m0[0])))
      else $error("pin a level wrong while stopped");
   a_pin_b_level: assert property (
      quiet == 3'h7 && !m1[7] && !prt[2] |->
      pin_b_o == (prt[3] | (m1[1] & m1[0])))
      else $error("pin b level wrong while stopped");
   c_irq0: cover property (irq0_o);
   c_irq1: cover property (irq1_o);
   c_pin_drive: cover property (pin_a_oe_o && pin_a_o);
endmodule
